// file: verilog/csts_top.sv
// slot trigger select bank: apb registers, trigger routing and slot flags
`timescale 1ns/1ns
`default_nettype none
module csts_top
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer0ExpiryPulse,
	input wire logic timer1ExpiryPulse,
	input wire logic timer2ExpiryPulse,
	input wire logic externalLine2ConversionRequest,
	input wire logic [csts_pkg::PWM_COUNT-1:0] pwmConversionRequestA,
	input wire logic [csts_pkg::PWM_COUNT-1:0] pwmConversionRequestB,
	input wire logic adcInt1,
	input wire logic adcInt2,
	input wire logic [csts_pkg::SLOT_COUNT-1:0] pairSamplingEnable,
	input wire logic startValid,
	input wire logic [3:0] startSlot,
	output logic [csts_pkg::SLOT_COUNT-1:0] pendingConversionFlags,
	output logic [csts_pkg::SLOT_COUNT-1:0] missedTriggerFlags,
	output logic convStart,
	output logic [3:0] convSlot,
	output logic [3:0] convChannel,
	output logic [6:0] convWindowCycles,
	output logic convChannelValid,
	output logic convWindowValid
);
	localparam int NS = csts_pkg::SLOT_COUNT;

	logic [15:0] slotCtrl [NS];
	logic [15:0] retrigLow;
	logic [15:0] retrigHigh;
	logic [csts_pkg::EVENT_COUNT-1:0] hwEvents;
	logic [NS-1:0] hwHit;
	logic [NS-1:0] slotEvent;
	logic [NS-1:0] forceBits;
	logic [NS-1:0] missedClearBits;
	logic [NS-1:0] startBits;
	logic [5:0] regIdx;
	logic setupPhase;
	logic accessWrite;
	logic addrOk;
	logic [31:0] next_prdata;
	logic startTaken;

	function automatic logic [15:0] slot_read(input logic [15:0] ctrl);
		slot_read = ctrl & csts_pkg::CTRL_WRITE_MASK;
	endfunction

	// bus decode; the slave never waits so every access ends in one cycle
	assign regIdx = paddr[7:2];
	assign setupPhase = psel && !penable;
	assign accessWrite = psel && penable && pwrite && addrOk;
	assign pready = 1'b1;

	always_comb
	begin
		addrOk = 1'b0;
		if (paddr[1:0] == 2'h0)
		begin
			if (regIdx >= csts_pkg::IDX_SLOT_FIRST && regIdx <= csts_pkg::IDX_SLOT_LAST)
				addrOk = 1'b1;
			else if (regIdx >= csts_pkg::IDX_PENDING && regIdx <= csts_pkg::IDX_RETRIG_HIGH)
				addrOk = 1'b1;
		end
	end

	always_comb
	begin
		next_prdata = 32'h00000000;
		if (regIdx >= csts_pkg::IDX_SLOT_FIRST && regIdx <= csts_pkg::IDX_SLOT_LAST)
			next_prdata[15:0] = slot_read(slotCtrl[regIdx[3:0]]);
		else if (regIdx == csts_pkg::IDX_PENDING)
			next_prdata[15:0] = pendingConversionFlags;
		else if (regIdx == csts_pkg::IDX_MISSED)
			next_prdata[15:0] = missedTriggerFlags;
		else if (regIdx == csts_pkg::IDX_RETRIG_LOW)
			next_prdata[15:0] = retrigLow;
		else if (regIdx == csts_pkg::IDX_RETRIG_HIGH)
			next_prdata[15:0] = retrigHigh;
	end

	// read data and error are caught in the setup cycle so they come from flops
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			prdata <= 32'h00000000;
		else if (setupPhase && !pwrite)
			prdata <= next_prdata;
	end

	logic errLatch;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			errLatch <= 1'b0;
		else if (setupPhase)
			errLatch <= !addrOk;
	end
	assign pslverr = psel && penable && errLatch;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < NS; i++)
				slotCtrl[i] <= csts_pkg::CTRL_RESET;
		end
		else if (accessWrite && regIdx >= csts_pkg::IDX_SLOT_FIRST
			&& regIdx <= csts_pkg::IDX_SLOT_LAST)
		begin
			slotCtrl[regIdx[3:0]] <= pwdata[15:0] & csts_pkg::CTRL_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			retrigLow <= csts_pkg::RETRIG_RESET;
			retrigHigh <= csts_pkg::RETRIG_RESET;
		end
		else if (accessWrite)
		begin
			if (regIdx == csts_pkg::IDX_RETRIG_LOW)
				retrigLow <= pwdata[15:0];
			if (regIdx == csts_pkg::IDX_RETRIG_HIGH)
				retrigHigh <= pwdata[15:0];
		end
	end

	// write-one strobes; zeros are ignored
	assign forceBits = (accessWrite && regIdx == csts_pkg::IDX_FORCE) ? pwdata[15:0] : '0;
	assign missedClearBits = (accessWrite && regIdx == csts_pkg::IDX_MISSED_CLEAR)
		? pwdata[15:0] : '0;

	// event vector indexed by trigger code; bit zero is the software-only code
	always_comb
	begin
		hwEvents = '0;
		hwEvents[csts_pkg::TRIG_TIMER0] = timer0ExpiryPulse;
		hwEvents[csts_pkg::TRIG_TIMER0 + 5'h01] = timer1ExpiryPulse;
		hwEvents[csts_pkg::TRIG_TIMER0 + 5'h02] = timer2ExpiryPulse;
		hwEvents[csts_pkg::TRIG_EXT2] = externalLine2ConversionRequest;
		for (int m = 0; m < csts_pkg::PWM_COUNT; m++)
		begin
			hwEvents[csts_pkg::TRIG_PWM_FIRST + 2 * m] = pwmConversionRequestA[m];
			hwEvents[csts_pkg::TRIG_PWM_FIRST + 2 * m + 1] = pwmConversionRequestB[m];
		end
	end

	// a start only counts for a slot that is really pending
	assign startTaken = startValid && pendingConversionFlags[startSlot];
	assign startBits = startTaken ? (16'h0001 << startSlot) : '0;

	for (genvar s = 0; s < NS; s++)
	begin : g_slot
		logic [1:0] rsel;
		assign rsel = csts_pkg::retrig_field(retrigLow, retrigHigh, 4'(s));

		csts_trigger_mux u_mux
		(
			.code(slotCtrl[s][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB]),
			.hwEvents(hwEvents),
			.hit(hwHit[s])
		);

		// an interrupt retrigger choice replaces the slot's hardware trigger; the force strobe still sets the slot
		always_comb
		begin
			if (rsel == csts_pkg::RETRIG_INT1)
				slotEvent[s] = adcInt1;
			else if (rsel == csts_pkg::RETRIG_INT2)
				slotEvent[s] = adcInt2;
			else
				slotEvent[s] = hwHit[s];
		end

		csts_slot_flag u_flag
		(
			.clk_sys(clk_sys),
			.rst(rst),
			.setReq(slotEvent[s] | forceBits[s]),
			.startClear(startBits[s]),
			.missedClear(missedClearBits[s]),
			.pending(pendingConversionFlags[s]),
			.missed(missedTriggerFlags[s])
		);
	end

	// the granted slot's settings are handed to the converter with the start
	logic [15:0] grantCtrl;
	logic [5:0] grantWin;
	logic [3:0] grantCh;
	assign grantCtrl = slotCtrl[startSlot];
	assign grantWin = grantCtrl[csts_pkg::WIN_MSB:csts_pkg::WIN_LSB];
	assign grantCh = grantCtrl[csts_pkg::CH_MSB:csts_pkg::CH_LSB];

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			convStart <= 1'b0;
		else
			convStart <= startTaken;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			convSlot <= 4'h0;
			convChannel <= 4'h0;
			convWindowCycles <= 7'h00;
			convChannelValid <= 1'b0;
			convWindowValid <= 1'b0;
		end
		else if (startTaken)
		begin
			convSlot <= startSlot;
			convChannel <= grantCh;
			convChannelValid <= !pairSamplingEnable[startSlot]
				|| grantCh <= csts_pkg::CH_PAIR_LAST;
			convWindowCycles <= {1'b0, grantWin} + 7'h01;
			convWindowValid <= grantWin >= csts_pkg::WIN_MIN;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	rsvd_bit_zero_a: assert property (
		slotCtrl[0][csts_pkg::RSVD_BIT] == 1'b0 && slotCtrl[15][csts_pkg::RSVD_BIT] == 1'b0)
		else $error("reserved control bit not zero");

	slot_write_a: assert property (
		accessWrite && regIdx == csts_pkg::IDX_SLOT_FIRST
		|=> slotCtrl[0] == ($past(pwdata[15:0]) & csts_pkg::CTRL_WRITE_MASK))
		else $error("slot zero write not stored");

	event_sets_a: assert property (
		(slotEvent | forceBits) != '0
		|=> (pendingConversionFlags & $past(slotEvent | forceBits)) == $past(slotEvent | forceBits))
		else $error("trigger did not set pending flag");

	start_clears_a: assert property (
		startTaken && !slotEvent[startSlot] && !forceBits[startSlot]
		|=> !pendingConversionFlags[$past(startSlot)] ##0 convStart)
		else $error("start did not clear pending flag");

	invalid_code_a: assert property (
		!csts_pkg::trigger_valid(slotCtrl[3][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB])
		|-> !hwHit[3])
		else $error("invalid code produced a hit");

	timer_map_a: assert property (
		slotCtrl[0][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB] == 5'h03 && retrigLow[1:0] == 2'h0
		|-> slotEvent[0] == timer2ExpiryPulse)
		else $error("timer code mapped wrongly");

	ext_map_a: assert property (
		slotCtrl[0][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB] == csts_pkg::TRIG_EXT2
		&& retrigLow[1:0] == 2'h0 |-> slotEvent[0] == externalLine2ConversionRequest)
		else $error("external line code mapped wrongly");

	pwm_map_a: assert property (
		slotCtrl[0][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB] == csts_pkg::TRIG_LAST
		&& retrigLow[1:0] == 2'h0 |-> slotEvent[0] == pwmConversionRequestB[6])
		else $error("last pwm code mapped wrongly");

	override_a: assert property (
		retrigHigh[15:14] == csts_pkg::RETRIG_INT2 |-> slotEvent[15] == adcInt2)
		else $error("retrigger select did not override");

	window_len_a: assert property (
		startTaken ##1 convStart |-> convWindowCycles == 7'($past(grantWin)) + 7'h01
		&& convWindowValid == ($past(grantWin) >= 6'h06))
		else $error("sample window wrong");

	pair_chan_a: assert property (
		convStart && convChannel > 4'h7 && pairSamplingEnable[convSlot] |-> !convChannelValid
		or $changed(pairSamplingEnable))
		else $error("pair mode accepted high channel");

	// the missed flag must not move when a set meets the start clear
	set_beats_clear_a: assert property (
		startTaken && slotEvent[startSlot] && missedClearBits == '0
		|=> pendingConversionFlags[$past(startSlot)]
		&& missedTriggerFlags[$past(startSlot)] == $past(missedTriggerFlags[startSlot]))
		else $error("set lost against start clear");

	rsvd_read_a: assert property (
		setupPhase && !pwrite && regIdx >= csts_pkg::IDX_SLOT_FIRST
		&& regIdx <= csts_pkg::IDX_SLOT_LAST |=> prdata[csts_pkg::RSVD_BIT] == 1'b0)
		else $error("reserved bit read as one");

	software_only_a: assert property (
		slotCtrl[0][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB] == csts_pkg::TRIG_SOFTWARE
		&& retrigLow[1:0] == csts_pkg::RETRIG_NONE |-> !hwHit[0] && !slotEvent[0])
		else $error("software code took a hardware event");

	timer0_map_a: assert property (
		slotCtrl[0][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB] == csts_pkg::TRIG_TIMER0
		&& retrigLow[1:0] == csts_pkg::RETRIG_NONE
		|-> slotEvent[0] == timer0ExpiryPulse)
		else $error("timer zero code mapped wrongly");

	pwm_first_a: assert property (
		slotCtrl[0][csts_pkg::TRIG_MSB:csts_pkg::TRIG_LSB] == csts_pkg::TRIG_PWM_FIRST
		&& retrigLow[1:0] == csts_pkg::RETRIG_NONE
		|-> slotEvent[0] == pwmConversionRequestA[0])
		else $error("first pwm code mapped wrongly");

	conv_load_a: assert property (
		startTaken |=> convStart && convSlot == $past(startSlot) && convChannel == $past(grantCh))
		else $error("start not handed to converter");

	no_start_a: assert property (
		!startTaken |=> !convStart)
		else $error("start pulse without grant");

	bad_addr_a: assert property (
		psel && !penable && !addrOk ##1 psel && penable |-> pslverr)
		else $error("unmapped access not refused");

	trig_pend_c: cover property (slotEvent[0] ##1 pendingConversionFlags[0]);
	set_clear_c: cover property (startTaken && slotEvent[startSlot]);
	miss_c: cover property (missedTriggerFlags != '0);
	start_c: cover property (startTaken ##1 convStart);
	override_c: cover property (retrigLow[1:0] == csts_pkg::RETRIG_INT1 && adcInt1);
endmodule
`default_nettype wire

// file: include/csts_pkg.sv
// constants, field layout and helper functions for the slot trigger select bank
package csts_pkg;
	localparam int SLOT_COUNT = 16;
	localparam int EVENT_COUNT = 19;
	localparam int PWM_COUNT = 7;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_SLOT_FIRST = 6'h20;
	localparam logic [5:0] IDX_SLOT_LAST = 6'h2f;
	localparam logic [5:0] IDX_PENDING = 6'h10;
	localparam logic [5:0] IDX_FORCE = 6'h11;
	localparam logic [5:0] IDX_MISSED = 6'h12;
	localparam logic [5:0] IDX_MISSED_CLEAR = 6'h13;
	localparam logic [5:0] IDX_RETRIG_LOW = 6'h14;
	localparam logic [5:0] IDX_RETRIG_HIGH = 6'h15;
	// slot control field layout
	localparam int TRIG_MSB = 15;
	localparam int TRIG_LSB = 11;
	localparam int RSVD_BIT = 10;
	localparam int CH_MSB = 9;
	localparam int CH_LSB = 6;
	localparam int WIN_MSB = 5;
	localparam int WIN_LSB = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WRITE_MASK = 16'hfbff;
	localparam logic [15:0] RETRIG_RESET = 16'h0000;
	// trigger source codes
	localparam logic [4:0] TRIG_SOFTWARE = 5'h00;
	localparam logic [4:0] TRIG_TIMER0 = 5'h01;
	localparam logic [4:0] TRIG_EXT2 = 5'h04;
	localparam logic [4:0] TRIG_PWM_FIRST = 5'h05;
	localparam logic [4:0] TRIG_LAST = 5'h12;
	// interrupt retrigger codes
	localparam logic [1:0] RETRIG_NONE = 2'h0;
	localparam logic [1:0] RETRIG_INT1 = 2'h1;
	localparam logic [1:0] RETRIG_INT2 = 2'h2;
	// sample window and channel limits
	localparam logic [5:0] WIN_MIN = 6'h06;
	localparam logic [3:0] CH_PAIR_LAST = 4'h7;

	function automatic logic trigger_valid(input logic [4:0] code);
		trigger_valid = (code != TRIG_SOFTWARE) && (code <= TRIG_LAST);
	endfunction

	function automatic logic [1:0] retrig_field(input logic [15:0] lowReg,
		input logic [15:0] highReg, input logic [3:0] slot);
		logic [15:0] src;
		src = slot[3] ? highReg : lowReg;
		retrig_field = src[{slot[2:0], 1'b0} +: 2];
	endfunction
endpackage

// file: verilog/csts_trigger_mux.sv
// one slot's hardware trigger selector
`timescale 1ns/1ns
`default_nettype none
module csts_trigger_mux
(
	input wire logic [4:0] code,
	input wire logic [csts_pkg::EVENT_COUNT-1:0] hwEvents,
	output logic hit
);
	// codes above the last valid one and code zero pick no event
	assign hit = csts_pkg::trigger_valid(code) && hwEvents[code];
endmodule
`default_nettype wire

// file: verilog/csts_slot_flag.sv
// pending and missed-trigger flags of one conversion slot
`timescale 1ns/1ns
`default_nettype none
module csts_slot_flag
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic setReq,
	input wire logic startClear,
	input wire logic missedClear,
	output logic pending,
	output logic missed
);
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pending <= 1'b0;
		else if (setReq)
			pending <= 1'b1;
		else if (startClear)
			pending <= 1'b0;
	end

	// a set that meets a start clear leaves the missed flag alone
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			missed <= 1'b0;
		else if (setReq && pending && !startClear)
			missed <= 1'b1;
		else if (missedClear)
			missed <= 1'b0;
	end
endmodule
`default_nettype wire

// file: sim/csts_trigger_source.sv
// partner model: timers, external line and pwm modules pulsing the slot triggers
`timescale 1ns/1ns
`default_nettype none
module csts_trigger_source
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic go,
	input wire logic [4:0] code,
	output logic timer0ExpiryPulse,
	output logic timer1ExpiryPulse,
	output logic timer2ExpiryPulse,
	output logic externalLine2ConversionRequest,
	output logic [csts_pkg::PWM_COUNT-1:0] pwmConversionRequestA,
	output logic [csts_pkg::PWM_COUNT-1:0] pwmConversionRequestB,
	output logic adcInt1,
	output logic adcInt2
);
	// code 1fh pulses every source at once; 14h and 15h are the two interrupts
	function automatic logic sel(input logic [4:0] k);
		sel = go && (code == k || code == 5'h1f);
	endfunction
	// every source is a one-cycle pulse, as the on-chip logic gives it
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			timer0ExpiryPulse <= 1'b0;
			timer1ExpiryPulse <= 1'b0;
			timer2ExpiryPulse <= 1'b0;
			externalLine2ConversionRequest <= 1'b0;
			pwmConversionRequestA <= '0;
			pwmConversionRequestB <= '0;
			adcInt1 <= 1'b0;
			adcInt2 <= 1'b0;
		end
		else
		begin
			timer0ExpiryPulse <= sel(5'h01);
			timer1ExpiryPulse <= sel(5'h02);
			timer2ExpiryPulse <= sel(5'h03);
			externalLine2ConversionRequest <= sel(5'h04);
			for (int m = 0; m < csts_pkg::PWM_COUNT; m++)
			begin
				pwmConversionRequestA[m] <= sel(5'(5 + 2 * m));
				pwmConversionRequestB[m] <= sel(5'(6 + 2 * m));
			end
			adcInt1 <= sel(5'h14);
			adcInt2 <= sel(5'h15);
		end
	end
endmodule
`default_nettype wire

// file: sim/conversion_slot_trigger_select_bench.sv
// self-checking bench for the slot trigger select bank
`timescale 1ns/1ns
`default_nettype none
module conversion_slot_trigger_select_bench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic go = 1'b0;
	logic [4:0] code = 5'h00;
	logic [15:0] pair = 16'h0002;
	logic startValid = 1'b0;
	logic [3:0] startSlot = 4'h0;
	logic [31:0] prdata;
	logic pready, pslverr, t0, t1, t2, ext, int1, int2, convStart;
	logic convChannelValid, convWindowValid;
	logic [6:0] pwmA, pwmB, convWindowCycles;
	logic [15:0] pend, miss;
	logic [3:0] convSlot, convChannel;
	logic [31:0] d;
	logic e;
	int nErrors = 0;
	int nChecks = 0;
	always #50 clk_sys = ~clk_sys;
	csts_trigger_source src (.clk_sys, .rst, .go, .code, .timer0ExpiryPulse(t0),
		.timer1ExpiryPulse(t1), .timer2ExpiryPulse(t2), .externalLine2ConversionRequest(ext),
		.pwmConversionRequestA(pwmA), .pwmConversionRequestB(pwmB), .adcInt1(int1),
		.adcInt2(int2));
	csts_top dut (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .timer0ExpiryPulse(t0), .timer1ExpiryPulse(t1),
		.timer2ExpiryPulse(t2), .externalLine2ConversionRequest(ext),
		.pwmConversionRequestA(pwmA), .pwmConversionRequestB(pwmB), .adcInt1(int1),
		.adcInt2(int2), .pairSamplingEnable(pair), .startValid, .startSlot,
		.pendingConversionFlags(pend), .missedTriggerFlags(miss), .convStart, .convSlot,
		.convChannel, .convWindowCycles, .convChannelValid, .convWindowValid);
	task testDone;
		if (nErrors == 0 && nChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nChecks++;
		if (got !== exp)
		begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 16; k++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 16)
		begin
			nErrors++;
			testDone;
		end
	endtask
	task fire(input logic [4:0] c);
		@(posedge clk_sys);
		go <= 1'b1;
		code <= c;
		@(posedge clk_sys);
		go <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task start(input logic [3:0] s);
		@(posedge clk_sys);
		startValid <= 1'b1;
		startSlot <= s;
		@(posedge clk_sys);
		startValid <= 1'b0;
		@(negedge clk_sys);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		nErrors++;
		testDone;
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, 8'h80, 32'h0, d, e);
		chk("slot0 reset", 32'h0, d);
		for (int i = 0; i < 16; i++)
			apb(1'b1, 8'(8'h80 + 4 * i), 32'(16'hffff - i), d, e);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b0, 8'(8'h80 + 4 * i), 32'h0, d, e);
			chk("slot readback", 32'((16'hffff - i) & 16'hfbff), d);
		end
		apb(1'b0, 8'hfc, 32'h0, d, e);
		chk("unmapped error", 32'h1, 32'(e));
		// codes 0 to 19: a neighbouring source must not hit; the chosen one must for 1 to 18, while 0 and 19 take no hit even with all sources
		for (int c = 0; c < 20; c++)
		begin
			apb(1'b1, 8'h80, 32'((c << 11) | 6), d, e);
			fire(5'(c + 1));
			chk("pending by other", 32'h0, 32'(pend[0]));
			fire((c >= 1 && c <= 18) ? 5'(c) : 5'h1f);
			chk("pending by code", 32'(c >= 1 && c <= 18), 32'(pend[0]));
			if (c >= 1 && c <= 18)
			begin
				start(4'h0);
				chk("start pulse", 32'h1, 32'(convStart));
				chk("window", 32'h7, 32'(convWindowCycles));
				chk("pending cleared", 32'h0, 32'(pend[0]));
				chk("valid flags", 32'h3, 32'({convChannelValid, convWindowValid}));
			end
		end
		apb(1'b1, 8'h44, 32'h1, d, e);
		@(negedge clk_sys);
		chk("software force", 32'h1, 32'(pend[0]));
		start(4'h0);
		apb(1'b1, 8'h84, 32'h0a05, d, e);
		fire(5'h01);
		start(4'h1);
		chk("slot", 32'h1, 32'(convSlot));
		chk("channel", 32'h8, 32'(convChannel));
		chk("pair invalid", 32'h0, 32'(convChannelValid));
		chk("short window", 32'h6, 32'(convWindowCycles));
		chk("window invalid", 32'h0, 32'(convWindowValid));
		fire(5'h01);
		// set and clear of slot 1 land on the same edge
		@(posedge clk_sys);
		go <= 1'b1;
		code <= 5'h01;
		@(posedge clk_sys);
		go <= 1'b0;
		startValid <= 1'b1;
		startSlot <= 4'h1;
		@(posedge clk_sys);
		startValid <= 1'b0;
		@(negedge clk_sys);
		chk("set wins", 32'h1, 32'(pend[1]));
		chk("missed kept", 32'h0, 32'(miss[1]));
		fire(5'h01);
		apb(1'b0, 8'h48, 32'h0, d, e);
		chk("missed set", 32'h2, d);
		apb(1'b1, 8'h4c, 32'h2, d, e);
		apb(1'b0, 8'h48, 32'h0, d, e);
		chk("missed cleared", 32'h0, d);
		apb(1'b0, 8'h40, 32'h0, d, e);
		chk("pending reg", 32'h2, d);
		apb(1'b1, 8'h50, 32'h1, d, e);
		fire(5'h15);
		chk("other interrupt", 32'h0, 32'(pend[0]));
		fire(5'h14);
		chk("interrupt override", 32'h1, 32'(pend[0]));
		apb(1'b1, 8'h54, 32'h8000, d, e);
		fire(5'h15);
		chk("high override", 32'h1, 32'(pend[15]));
		testDone;
	end
endmodule
`default_nettype wire
